// ===== core/pmt_pkg.sv
// Constants and types shared by the table-read block and its vector arbiter.
// Assumes a single core clock domain; program memory sits outside the block.
package pmt_pkg;
   localparam int ADDR_W_DEF = 13;
   localparam int WORD_W_DEF = 16;
   localparam int TBL_PTR_W = 8;
   localparam int VEC_W = 13;
   localparam int N_MF_SRC = 5;
   localparam logic [12:0] VEC_SERIAL = 13'h0014;
   localparam logic [12:0] VEC_MULTI = 13'h0018;
   localparam logic [12:0] VEC_RESET = 13'h0000;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [4:0] MF_RST = 5'h00;
   // Multi-function source positions
   localparam int MF_TIMEBASE = 0;
   localparam int MF_RTC = 1;
   localparam int MF_CONV_DONE = 2;
   localparam int MF_EXT_PIN = 3;
   localparam int MF_TIMER2 = 4;
   typedef enum {PMT_IDLE, PMT_FETCH, PMT_CAPTURE} pmt_state_t;
endpackage : pmt_pkg

// ===== core/pmt_irq_if.sv
// Carrier between the table-read top and its vector arbiter.
// Assumes all signals are on core_clk.
`timescale 1ns/1ns
`default_nettype none
interface pmt_irq_if;
   import pmt_pkg::*;
   logic [N_MF_SRC-1:0] mf_req;
   logic [N_MF_SRC-1:0] mf_en;
   logic ser_req;
   logic ser_en;
   logic stack_full;
   logic take;
   logic ack;
   logic [VEC_W-1:0] vec;
   logic mf_flag;
   logic ser_flag;
   modport arb (input mf_req, mf_en, ser_req, ser_en, stack_full, take, output ack, vec, mf_flag, ser_flag);
   modport core (output mf_req, mf_en, ser_req, ser_en, stack_full, take, input ack, vec, mf_flag, ser_flag);
endinterface : pmt_irq_if
`default_nettype wire

// ===== core/pmt_irq_arb.sv
// Vector arbiter for the serial and shared multi-function requests.
// Assumes requests are one-cycle pulses from logic on core_clk.
`timescale 1ns/1ns
`default_nettype none
module pmt_irq_arb (
   input wire logic core_clk,
   input wire logic resetn,
   pmt_irq_if.arb irq
);
   import pmt_pkg::*;

   logic mf_flag_r, mf_flag_nxt;
   logic ser_flag_r, ser_flag_nxt;
   logic ack_r, ack_nxt;
   logic [VEC_W-1:0] vec_r, vec_nxt;
   logic mf_hit, can_ack;

   always_comb begin
      mf_hit = |(irq.mf_req & irq.mf_en);
      // A full stack keeps the flags but holds off the acknowledge
      can_ack = irq.take && !irq.stack_full && !ack_r;
      ack_nxt = 1'b0;
      vec_nxt = vec_r;
      ser_flag_nxt = ser_flag_r;
      mf_flag_nxt = mf_flag_r;
      if (can_ack && ser_flag_r) begin
         ack_nxt = 1'b1;
         vec_nxt = VEC_SERIAL;
         ser_flag_nxt = 1'b0;
      end else if (can_ack && mf_flag_r) begin
         ack_nxt = 1'b1;
         vec_nxt = VEC_MULTI;
         mf_flag_nxt = 1'b0;
      end
      // New requests win over the acknowledge clear
      if (irq.ser_req && irq.ser_en) begin
         ser_flag_nxt = 1'b1;
      end
      if (mf_hit) begin
         mf_flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mf_flag_r <= 1'b0;
         ser_flag_r <= 1'b0;
         ack_r <= 1'b0;
         vec_r <= VEC_RESET;
      end else begin
         mf_flag_r <= mf_flag_nxt;
         ser_flag_r <= ser_flag_nxt;
         ack_r <= ack_nxt;
         vec_r <= vec_nxt;
      end
   end

   assign irq.ack = ack_r;
   assign irq.vec = vec_r;
   assign irq.mf_flag = mf_flag_r;
   assign irq.ser_flag = ser_flag_r;

   a_ack_needs_room: assert property (@(posedge core_clk) disable iff (!resetn)
      ack_r |-> !$past(irq.stack_full) && $past(irq.take))
      else $error("acknowledge given with a full stack");
   a_full_holds_off: assert property (@(posedge core_clk) disable iff (!resetn)
      (mf_flag_r && irq.stack_full) |=> !ack_r && mf_flag_r)
      else $error("request lost or acknowledged while stack full");
   a_mf_vector: assert property (@(posedge core_clk) disable iff (!resetn)
      (irq.take && !irq.stack_full && !ack_r && mf_flag_r && !ser_flag_r) |=> ack_r && vec_r == VEC_MULTI)
      else $error("shared vector not taken");
   a_ser_vector: assert property (@(posedge core_clk) disable iff (!resetn)
      (irq.take && !irq.stack_full && !ack_r && ser_flag_r) |=> ack_r && vec_r == VEC_SERIAL)
      else $error("serial vector not taken");
endmodule : pmt_irq_arb
`default_nettype wire

// ===== core/pmt_table_read.sv
// Table-read unit: forms the program memory table address, returns the low byte
// to data memory and the high part to the read-only table high latch.
// Assumes a program memory with one cycle of synchronous read latency and a core
// that issues table reads and interrupt takes as one-cycle pulses on core_clk.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Time base, clock, converter, peripheral pin and timer 2 requests share the vector at 018H.
// - The shared vector is taken only for an enabled source and while the stack has a free level.
// - A current-page read addresses program memory with the program counter high bits above the pointer.
// - A last-page read forces every address bit above bit 7 to one, above the pointer byte.
// - The table pointer byte always supplies the low eight address bits.
// - The low byte of the fetched word is written to the data memory operand.
// - The upper part of the word loads the table high latch, unused bits reading zero.
// - The address is 13, 12 or 11 bits wide to match the program memory size.
// - A table read takes two cycles, both writes done by the end of the second.
// - The table high latch cannot be written by software, only by table reads.
// - Every word of the reachable page can be read as table data.
// - With the stack full an enabled request is kept but not acknowledged.
// - The serial interface vector sits at 014H, just below the shared vector.
module pmt_table_read #(
   parameter int ADDR_W = pmt_pkg::ADDR_W_DEF,
   parameter int WORD_W = pmt_pkg::WORD_W_DEF
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic tab_issue,
   input wire logic tab_last_page,
   input wire logic [ADDR_W-9:0] program_counter_high_bits,
   input wire logic [pmt_pkg::TBL_PTR_W-1:0] table_ptr,
   input wire logic [7:0] dest_addr,
   output logic [ADDR_W-1:0] pm_addr,
   output logic pm_rd,
   input wire logic [WORD_W-1:0] pm_rdata,
   output logic dm_we,
   output logic [7:0] dm_addr,
   output logic [7:0] dm_wdata,
   output logic [7:0] table_high_latch,
   output logic tab_busy,
   output logic tab_done,
   input wire logic [pmt_pkg::N_MF_SRC-1:0] mf_req,
   input wire logic [pmt_pkg::N_MF_SRC-1:0] mf_en,
   input wire logic ser_req,
   input wire logic ser_en,
   input wire logic stack_full,
   input wire logic irq_take,
   output logic irq_ack,
   output logic [pmt_pkg::VEC_W-1:0] irq_vector,
   output logic mf_pending,
   output logic ser_pending
);
   import pmt_pkg::*;

   pmt_state_t state_r, state_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic rd_r, rd_nxt;
   logic [7:0] dest_r, dest_nxt;
   logic we_r, we_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic [7:0] latch_r, latch_nxt;
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;

   // Address width follows the parameter, so every implemented word is reachable
   function automatic logic [ADDR_W-1:0] form_addr(input logic last, input logic [ADDR_W-9:0] pch,
                                                   input logic [7:0] ptr);
      logic [ADDR_W-9:0] page;
      page = last ? {(ADDR_W-8){1'b1}} : pch;
      form_addr = {page, ptr};
   endfunction : form_addr

   // Upper word bits zero-extended into the latch byte
   function automatic logic [7:0] high_part(input logic [WORD_W-1:0] w);
      logic [15:0] wide;
      wide = 16'h0000;
      wide[WORD_W-1:0] = w;
      high_part = wide[15:8];
   endfunction : high_part

   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      rd_nxt = 1'b0;
      dest_nxt = dest_r;
      we_nxt = 1'b0;
      wdata_nxt = wdata_r;
      latch_nxt = latch_r;
      done_nxt = 1'b0;
      busy_nxt = busy_r;
      case (state_r)
         PMT_IDLE: begin
            // Issues while busy are ignored; the core never overlaps them
            if (tab_issue) begin
               addr_nxt = form_addr(tab_last_page, program_counter_high_bits, table_ptr);
               dest_nxt = dest_addr;
               rd_nxt = 1'b1;
               busy_nxt = 1'b1;
               state_nxt = PMT_FETCH;
            end
         end
         PMT_FETCH: begin
            state_nxt = PMT_CAPTURE;
         end
         PMT_CAPTURE: begin
            wdata_nxt = pm_rdata[7:0];
            we_nxt = 1'b1;
            // No software write path exists, so only this load changes the latch
            latch_nxt = high_part(pm_rdata);
            done_nxt = 1'b1;
            busy_nxt = 1'b0;
            state_nxt = PMT_IDLE;
         end
         default: begin
            busy_nxt = 1'b0;
            state_nxt = PMT_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= PMT_IDLE;
         addr_r <= '0;
         rd_r <= 1'b0;
         dest_r <= BYTE_RST;
         we_r <= 1'b0;
         wdata_r <= BYTE_RST;
         latch_r <= LATCH_RST;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         rd_r <= rd_nxt;
         dest_r <= dest_nxt;
         we_r <= we_nxt;
         wdata_r <= wdata_nxt;
         latch_r <= latch_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign pm_addr = addr_r;
   assign pm_rd = rd_r;
   assign dm_we = we_r;
   assign dm_addr = dest_r;
   assign dm_wdata = wdata_r;
   assign table_high_latch = latch_r;
   assign tab_busy = busy_r;
   assign tab_done = done_r;

   pmt_irq_if irq ();

   assign irq.mf_req = mf_req;
   assign irq.mf_en = mf_en;
   assign irq.ser_req = ser_req;
   assign irq.ser_en = ser_en;
   assign irq.stack_full = stack_full;
   assign irq.take = irq_take;

   pmt_irq_arb u_arb (
      .core_clk(core_clk),
      .resetn(resetn),
      .irq(irq.arb)
   );

   assign irq_ack = irq.ack;
   assign irq_vector = irq.vec;
   assign mf_pending = irq.mf_flag;
   assign ser_pending = irq.ser_flag;

   a_two_cycle_read: assert property (@(posedge core_clk) disable iff (!resetn)
      (tab_issue && state_r == PMT_IDLE) |=> rd_r && busy_r ##1 !we_r ##1 we_r && done_r && !busy_r)
      else $error("table read did not finish in two cycles");
   a_last_page_addr: assert property (@(posedge core_clk) disable iff (!resetn)
      (tab_issue && tab_last_page && state_r == PMT_IDLE)
      |=> addr_r[ADDR_W-1:8] == {(ADDR_W-8){1'b1}} && addr_r[7:0] == $past(table_ptr))
      else $error("last page address wrong");
   a_cur_page_addr: assert property (@(posedge core_clk) disable iff (!resetn)
      (tab_issue && !tab_last_page && state_r == PMT_IDLE)
      |=> addr_r == {$past(program_counter_high_bits), $past(table_ptr)})
      else $error("current page address wrong");
   a_low_byte_out: assert property (@(posedge core_clk) disable iff (!resetn)
      we_r |-> wdata_r == $past(pm_rdata[7:0]) && dm_addr == $past(dest_r, 2))
      else $error("low byte or destination wrong");
   a_latch_replaced: assert property (@(posedge core_clk) disable iff (!resetn)
      we_r |-> latch_r == high_part($past(pm_rdata)))
      else $error("table high latch not fully replaced");
   a_latch_read_only: assert property (@(posedge core_clk) disable iff (!resetn)
      !we_r |-> $stable(latch_r))
      else $error("table high latch changed outside a table read");
endmodule : pmt_table_read
`default_nettype wire

// ===== verif/pmt_pm_model.sv
// Program memory stand-in with one cycle of synchronous read latency.
// Assumes pm_rd is a one-cycle strobe on core_clk.
`timescale 1ns/1ns
`default_nettype none
module pmt_pm_model #(
   parameter int AW = 11,
   parameter int WW = 14
) (
   input wire logic core_clk,
   input wire logic pm_rd,
   input wire logic [AW-1:0] pm_addr,
   output logic [WW-1:0] pm_rdata
);
   logic [WW-1:0] word_r = '0;
   // Every address answers, no region fenced off; data turns over when not read
   always @(posedge core_clk) begin
      word_r <= pm_rd ? WW'((16'(pm_addr) * 16'h9E37) ^ 16'h5A3C) : ~word_r;
   end
   assign pm_rdata = word_r;
endmodule : pmt_pm_model
`default_nettype wire

// ===== verif/program_memory_table_read_tb_top.sv
// Self-checking bench for the table-read unit and its vector arbiter.
// Assumes the small variant: 11-bit table address and 14-bit program words.
`timescale 1ns/1ns
`default_nettype none
module program_memory_table_read_tb_top;
   import pmt_pkg::*;
   localparam int AW = 11;
   localparam int WW = 14;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic tab_issue = 1'b0;
   logic tab_last_page = 1'b0;
   logic [AW-9:0] pch = '0;
   logic [7:0] table_ptr = '0;
   logic [7:0] dest_addr = '0;
   logic [AW-1:0] pm_addr;
   logic [WW-1:0] pm_rdata;
   logic pm_rd, dm_we, tab_busy, tab_done, irq_ack, mf_pending, ser_pending;
   logic [7:0] dm_addr, dm_wdata, table_high_latch, last_hi;
   logic [N_MF_SRC-1:0] mf_req = '0;
   logic [N_MF_SRC-1:0] mf_en = '0;
   logic ser_req = 1'b0;
   logic ser_en = 1'b0;
   logic stack_full = 1'b0;
   logic irq_take = 1'b0;
   logic [VEC_W-1:0] irq_vector;
   int num_errors = 0;
   int n_checks = 0;
   int seed = 32'h525d;
   logic [15:0] exp_q[$];
   always #25 core_clk = ~core_clk;
   pmt_table_read #(.ADDR_W(AW), .WORD_W(WW)) i_dut (.core_clk(core_clk), .resetn(resetn),
      .tab_issue(tab_issue), .tab_last_page(tab_last_page), .program_counter_high_bits(pch),
      .table_ptr(table_ptr), .dest_addr(dest_addr), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
      .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .table_high_latch(table_high_latch),
      .tab_busy(tab_busy), .tab_done(tab_done), .mf_req(mf_req), .mf_en(mf_en), .ser_req(ser_req),
      .ser_en(ser_en), .stack_full(stack_full), .irq_take(irq_take), .irq_ack(irq_ack),
      .irq_vector(irq_vector), .mf_pending(mf_pending), .ser_pending(ser_pending));
   pmt_pm_model #(.AW(AW), .WW(WW)) i_pm (.core_clk(core_clk), .pm_rd(pm_rd), .pm_addr(pm_addr),
      .pm_rdata(pm_rdata));
   task automatic chk_tab(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_tab
   task automatic chk_irq(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_irq
   // Reference word: the partner's contents, upper bits beyond the word width zero
   function automatic logic [15:0] ref_word(input logic [AW-1:0] a);
      logic [15:0] w;
      w = (16'(a) * 16'h9E37) ^ 16'h5A3C;
      return 16'(w[WW-1:0]);
   endfunction : ref_word
   task automatic tab_read(input logic last, input logic poke);
      logic [AW-1:0] ea;
      logic [7:0] da;
      logic [15:0] w;
      @(negedge core_clk);
      tab_last_page = last;
      pch = 3'($random(seed));
      table_ptr = 8'($random(seed));
      dest_addr = 8'($random(seed));
      tab_issue = 1'b1;
      da = dest_addr;
      ea = last ? {{(AW-8){1'b1}}, table_ptr} : {pch, table_ptr};
      exp_q.push_back(ref_word(ea));
      @(negedge core_clk);
      chk_tab(16'({pm_rd, tab_busy}), 16'h3);
      chk_tab(16'(pm_addr), 16'(ea));
      // A second issue while busy must be dropped
      tab_issue = poke;
      table_ptr = ~table_ptr;
      @(negedge core_clk);
      tab_issue = 1'b0;
      chk_tab(16'({pm_rd, tab_busy}), 16'h1);
      @(negedge core_clk);
      w = exp_q.pop_front();
      last_hi = w[15:8];
      chk_tab(16'({dm_we, tab_done, pm_rd, tab_busy}), 16'hC);
      chk_tab(16'(dm_addr), 16'(da));
      chk_tab(16'(dm_wdata), 16'(w[7:0]));
      chk_tab(16'(table_high_latch), 16'(last_hi));
   endtask : tab_read
   task automatic irq_case(input int src, input logic en, input logic full);
      logic ser;
      ser = (src == N_MF_SRC);
      @(negedge core_clk);
      mf_en = N_MF_SRC'($random(seed));
      ser_en = ser ? en : 1'($random(seed));
      if (!ser)
         mf_en[src] = en;
      ser_req = ser;
      mf_req = ser ? '0 : N_MF_SRC'(1 << src);
      stack_full = full;
      @(negedge core_clk);
      mf_req = '0;
      ser_req = 1'b0;
      irq_take = 1'b1;
      chk_irq(16'({ser_pending, mf_pending}), 16'(en) << ser);
      @(negedge core_clk);
      chk_irq(16'(irq_ack), 16'(en & ~full));
      if (full) begin
         stack_full = 1'b0;
         chk_irq(16'({ser_pending, mf_pending}), 16'(en) << ser);
         @(negedge core_clk);
         chk_irq(16'(irq_ack), 16'(en));
      end
      if (en)
         chk_irq(16'(irq_vector), 16'(ser ? VEC_SERIAL : VEC_MULTI));
      irq_take = 1'b0;
      @(negedge core_clk);
      chk_irq(16'({irq_ack, ser_pending, mf_pending}), 16'h0);
   endtask : irq_case
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      resetn = 1'b1;
      chk_tab(16'(pm_addr), 16'h0);
      chk_irq(16'({irq_ack, irq_vector}), 16'h0);
      for (int i = 0; i < 24; i++)
         tab_read(i[0], i[1]);
      $display("test table reads done");
      for (int s = 0; s <= N_MF_SRC; s++)
         for (int k = 0; k < 4; k++)
            irq_case(s, k[0], k[1]);
      $display("test single requests done");
      // Serial and shared raised together: serial first, then shared one ack later
      mf_en = 5'h1F;
      ser_en = 1'b1;
      mf_req = 5'h10;
      ser_req = 1'b1;
      @(negedge core_clk);
      mf_req = '0;
      ser_req = 1'b0;
      irq_take = 1'b1;
      @(negedge core_clk);
      chk_irq(16'({irq_ack, irq_vector}), 16'({1'b1, VEC_SERIAL}));
      @(negedge core_clk);
      chk_irq(16'(irq_ack), 16'h0);
      @(negedge core_clk);
      chk_irq(16'({irq_ack, irq_vector}), 16'({1'b1, VEC_MULTI}));
      irq_take = 1'b0;
      chk_tab(16'(table_high_latch), 16'(last_hi));
      $display("test priority done");
      end_sim();
   end
   initial begin
      #200000;
      num_errors++;
      end_sim();
   end
endmodule : program_memory_table_read_tb_top
`default_nettype wire
